// >>> shared/flash_host_cfg.svh
`ifndef FLASH_HOST_CFG_SVH
`define FLASH_HOST_CFG_SVH

`define FH_CLK_NS 10
`define FH_CEIL_CYC(ns) (((ns) + `FH_CLK_NS - 1) / `FH_CLK_NS)
`define FH_FLOOR_CYC(ns) ((ns) / `FH_CLK_NS)
`define FH_MS_CYC(ms) ((ms) * 64'd1000000 / `FH_CLK_NS)

// Bus cycle timing, taken at the slower speed grade
`define FH_TWP_NS 60
`define FH_THOLD_NS 60
`define FH_TACC_NS 150
`define FH_SYNC_CYC 2

// Page load spacing and busy window
`define FH_LOAD_MIN_NS 300
`define FH_LOAD_MAX_NS 30000
`define FH_WINDOW_NS 100100
`define FH_WINDOW_SLACK_CYC 100

// Deep power-down release to first write strobe
`define FH_PD_EXIT_NS 1000

// Device internal time-outs, used here only as watchdogs
`define FH_ERASE_TO_MS 2000
`define FH_PROG_TO_MS 150

`define FH_READY_BIT 7

`endif

// >>> shared/flash_host_pkg.sv
package flash_host_pkg;

	typedef enum logic [2:0] {
		OP_WRITE = 3'b000,
		OP_PAGE = 3'b001,
		OP_READ = 3'b010,
		OP_POLL_ERASE = 3'b011,
		OP_POLL_PROG = 3'b100,
		OP_PD_ENTER = 3'b101,
		OP_PD_EXIT = 3'b110
	} op_e;

	typedef enum logic [2:0] {
		ST_IDLE = 3'b000,
		ST_CYCLE = 3'b001,
		ST_PD = 3'b010,
		ST_PD_EXIT = 3'b011,
		ST_WAIT_BUSY = 3'b100,
		ST_POLL = 3'b101
	} host_state_e;

	typedef enum logic [1:0] {
		CY_IDLE = 2'b00,
		CY_SETUP = 2'b01,
		CY_STROBE = 2'b10,
		CY_HOLD = 2'b11
	} cyc_state_e;

endpackage

// >>> core/flash_bus_cycle.sv
`timescale 1ns/1ps
`include "flash_host_cfg.svh"

module flash_bus_cycle #(
	parameter int AW = 20,
	parameter int DW = 16
) (
	input wire logic sys_clk,
	input wire logic resetn,
	input wire logic start,
	input wire logic is_read,
	input wire logic [AW-1:0] addr_in,
	input wire logic [DW-1:0] data_in,
	output logic idle,
	output logic done,
	output logic [DW-1:0] rd_data,
	output logic cs_n,
	output logic oe_n,
	output logic we_n,
	output logic [AW-1:0] addr_pin,
	output logic [DW-1:0] dq_out,
	output logic dq_oe,
	input wire logic [DW-1:0] dq_in
);
	localparam logic [4:0] WP_CYC = 5'(`FH_CEIL_CYC(`FH_TWP_NS));
	localparam logic [4:0] RD_CYC = 5'(`FH_CEIL_CYC(`FH_TACC_NS) + `FH_SYNC_CYC);
	localparam logic [4:0] HOLD_CYC = 5'(`FH_CEIL_CYC(`FH_THOLD_NS));

	flash_host_pkg::cyc_state_e st_r;
	logic [4:0] cnt_r;
	logic rd_r, cs_n_r, oe_n_r, we_n_r, dq_oe_r, done_r;
	logic [AW-1:0] addr_r;
	logic [DW-1:0] dout_r, rdata_r, dq_s1_r, dq_s2_r;

	assign idle = (st_r == flash_host_pkg::CY_IDLE);
	assign done = done_r;
	assign rd_data = rdata_r;
	assign cs_n = cs_n_r;
	assign oe_n = oe_n_r;
	assign we_n = we_n_r;
	assign addr_pin = addr_r;
	assign dq_out = dout_r;
	assign dq_oe = dq_oe_r;

	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			st_r <= flash_host_pkg::CY_IDLE;
			cnt_r <= '0;
			rd_r <= 1'b0;
			cs_n_r <= 1'b1;
			oe_n_r <= 1'b1;
			we_n_r <= 1'b1;
			dq_oe_r <= 1'b0;
			done_r <= 1'b0;
			addr_r <= '0;
			dout_r <= '0;
			rdata_r <= '0;
			dq_s1_r <= '0;
			dq_s2_r <= '0;
		end else begin
			dq_s1_r <= dq_in;
			dq_s2_r <= dq_s1_r;
			done_r <= 1'b0;
			unique case (st_r)
				flash_host_pkg::CY_IDLE: if (start) begin
					addr_r <= addr_in;
					dout_r <= data_in;
					rd_r <= is_read;
					cs_n_r <= 1'b0;
					dq_oe_r <= !is_read;
					st_r <= flash_host_pkg::CY_SETUP;
				end
				flash_host_pkg::CY_SETUP: begin
					// Output enable stays high for the whole write strobe
					oe_n_r <= !rd_r;
					we_n_r <= rd_r;
					cnt_r <= rd_r ? RD_CYC - 5'h01 : WP_CYC - 5'h01;
					st_r <= flash_host_pkg::CY_STROBE;
				end
				flash_host_pkg::CY_STROBE: if (cnt_r == 5'h00) begin
					oe_n_r <= 1'b1;
					we_n_r <= 1'b1;
					if (rd_r) begin
						rdata_r <= dq_s2_r;
					end
					cnt_r <= HOLD_CYC - 5'h01;
					st_r <= flash_host_pkg::CY_HOLD;
				end else begin
					cnt_r <= cnt_r - 5'h01;
				end
				flash_host_pkg::CY_HOLD: if (cnt_r == 5'h00) begin
					// Hold also covers data-bus turnaround after a read
					cs_n_r <= 1'b1;
					dq_oe_r <= 1'b0;
					done_r <= 1'b1;
					st_r <= flash_host_pkg::CY_IDLE;
				end else begin
					cnt_r <= cnt_r - 5'h01;
				end
			endcase
		end
	end

	property p_we_width;
		@(posedge sys_clk) disable iff (!resetn)
		$fell(we_n_r) |-> (!we_n_r)[*6] ##1 we_n_r;
	endproperty
	a_we_width: assert property (p_we_width) else $error("write strobe width wrong");

	property p_read_excl;
		@(posedge sys_clk) disable iff (!resetn)
		!oe_n_r |-> we_n_r && !dq_oe_r && !cs_n_r;
	endproperty
	a_read_excl: assert property (p_read_excl) else $error("read overlaps a write");

endmodule

// >>> core/flash_host_ctrl.sv
`timescale 1ns/1ps
`include "flash_host_cfg.svh"

module flash_host_ctrl #(
	parameter int AW = 20,
	parameter int DW = 16,
	parameter int unsigned WINDOW_CYC = 32'(`FH_CEIL_CYC(`FH_WINDOW_NS) + `FH_WINDOW_SLACK_CYC),
	parameter int unsigned ERASE_TO_CYC = 32'(`FH_MS_CYC(`FH_ERASE_TO_MS)),
	parameter int unsigned PROG_TO_CYC = 32'(`FH_MS_CYC(`FH_PROG_TO_MS))
) (
	input wire logic sys_clk,
	input wire logic resetn,
	input wire logic word_mode_strap,
	input wire logic cmd_valid,
	output logic cmd_ready,
	input wire flash_host_pkg::op_e cmd_op,
	input wire logic [AW-1:0] cmd_addr,
	input wire logic [DW-1:0] cmd_data,
	output logic rsp_valid,
	output logic [DW-1:0] rsp_data,
	output logic rsp_timeout,
	output logic page_late,
	output logic chip_select_a_n,
	output logic chip_select_b_n,
	output logic oe_n,
	output logic we_n,
	output logic width_select,
	output logic deep_powerdown_n,
	output logic [AW-1:0] addr_pin,
	output logic [DW-1:0] dq_out,
	output logic dq_oe,
	input wire logic [DW-1:0] dq_in,
	input wire logic ready_busy_out
);
	localparam logic [15:0] LOAD_MIN_CYC = 16'(`FH_CEIL_CYC(`FH_LOAD_MIN_NS));
	localparam logic [15:0] LOAD_MAX_CYC = 16'(`FH_FLOOR_CYC(`FH_LOAD_MAX_NS));
	localparam logic [31:0] PD_EXIT_CYC = 32'(`FH_CEIL_CYC(`FH_PD_EXIT_NS));
	localparam logic [7:0] PD_EXIT_CHK = 8'(`FH_CEIL_CYC(`FH_PD_EXIT_NS));

	flash_host_pkg::host_state_e st_r, st_nxt;
	logic init_r, width_r, pd_n_r, rb_s1_r, rb_s2_r, page_open_r;
	logic rsp_valid_r, rsp_timeout_r, page_late_r, rd_op_r;
	logic [DW-1:0] rsp_data_r;
	logic [AW-1:0] poll_addr_r;
	logic [15:0] gap_r;
	logic [31:0] tmr_r, wd_r;
	logic [7:0] since_pd_r;

	wire cyc_idle, cyc_done, cs_n;
	wire [DW-1:0] cyc_rdata;
	wire is_poll = (cmd_op == flash_host_pkg::OP_POLL_ERASE) ||
		(cmd_op == flash_host_pkg::OP_POLL_PROG);
	wire is_bus_op = (cmd_op == flash_host_pkg::OP_WRITE) ||
		(cmd_op == flash_host_pkg::OP_PAGE) || (cmd_op == flash_host_pkg::OP_READ);
	// Back-to-back page loads are held off until the minimum spacing has passed
	wire gap_ok = !(page_open_r && cmd_op == flash_host_pkg::OP_PAGE && gap_r < LOAD_MIN_CYC);
	wire idle_take = (st_r == flash_host_pkg::ST_IDLE) && gap_ok;
	wire pd_take = (st_r == flash_host_pkg::ST_PD) && (cmd_op == flash_host_pkg::OP_PD_EXIT);
	wire cmd_fire = cmd_valid && cmd_ready;
	wire poll_issue = (st_r == flash_host_pkg::ST_POLL) && cyc_idle && !cyc_done;
	wire cyc_start = (cmd_fire && is_bus_op) || poll_issue;
	wire cyc_read = poll_issue || (cmd_op == flash_host_pkg::OP_READ);
	wire [AW-1:0] cyc_addr = poll_issue ? poll_addr_r : cmd_addr;
	// Completion needs both the status bit and the pin to show ready
	wire poll_ready = cyc_rdata[`FH_READY_BIT] && rb_s2_r;
	wire poll_end = (st_r == flash_host_pkg::ST_POLL) && cyc_done;

	assign cmd_ready = init_r && cyc_idle && (idle_take || pd_take);
	assign rsp_valid = rsp_valid_r;
	assign rsp_data = rsp_data_r;
	assign rsp_timeout = rsp_timeout_r;
	assign page_late = page_late_r;
	assign chip_select_a_n = cs_n;
	assign chip_select_b_n = cs_n;
	assign width_select = width_r;
	assign deep_powerdown_n = pd_n_r;

	flash_bus_cycle #(.AW(AW), .DW(DW)) u_cycle (
		.sys_clk(sys_clk),
		.resetn(resetn),
		.start(cyc_start),
		.is_read(cyc_read),
		.addr_in(cyc_addr),
		.data_in(cmd_data),
		.idle(cyc_idle),
		.done(cyc_done),
		.rd_data(cyc_rdata),
		.cs_n(cs_n),
		.oe_n(oe_n),
		.we_n(we_n),
		.addr_pin(addr_pin),
		.dq_out(dq_out),
		.dq_oe(dq_oe),
		.dq_in(dq_in)
	);

	always_comb begin
		st_nxt = st_r;
		unique case (st_r)
			flash_host_pkg::ST_IDLE: if (cmd_fire) begin
				if (is_bus_op) begin
					st_nxt = flash_host_pkg::ST_CYCLE;
				end else if (is_poll) begin
					st_nxt = flash_host_pkg::ST_WAIT_BUSY;
				end else if (cmd_op == flash_host_pkg::OP_PD_ENTER) begin
					st_nxt = flash_host_pkg::ST_PD;
				end
			end
			flash_host_pkg::ST_CYCLE: if (cyc_done) begin
				st_nxt = flash_host_pkg::ST_IDLE;
			end
			flash_host_pkg::ST_PD: if (cmd_fire) begin
				st_nxt = flash_host_pkg::ST_PD_EXIT;
			end
			flash_host_pkg::ST_PD_EXIT: if (tmr_r == 32'h0000_0000) begin
				st_nxt = flash_host_pkg::ST_IDLE;
			end
			// Busy may lag the last page load by the whole load window
			flash_host_pkg::ST_WAIT_BUSY: if (!rb_s2_r || tmr_r == 32'h0000_0000) begin
				st_nxt = flash_host_pkg::ST_POLL;
			end
			flash_host_pkg::ST_POLL: if (cyc_done && (poll_ready || wd_r == 32'h0000_0000)) begin
				st_nxt = flash_host_pkg::ST_IDLE;
			end
			default: st_nxt = flash_host_pkg::ST_IDLE;
		endcase
	end

	// Width is a strap caught once after reset so it never moves mid-sequence
	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			init_r <= 1'b0;
			width_r <= 1'b0;
		end else if (!init_r) begin
			init_r <= 1'b1;
			width_r <= word_mode_strap;
		end
	end

	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			rb_s1_r <= 1'b1;
			rb_s2_r <= 1'b1;
			st_r <= flash_host_pkg::ST_IDLE;
			pd_n_r <= 1'b1;
		end else begin
			rb_s1_r <= ready_busy_out;
			rb_s2_r <= rb_s1_r;
			st_r <= st_nxt;
			pd_n_r <= (st_nxt != flash_host_pkg::ST_PD);
		end
	end

	// Strobes are only offered after the power-down recovery time
	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			tmr_r <= '0;
			wd_r <= '0;
			poll_addr_r <= '0;
		end else if (cmd_fire && is_poll) begin
			tmr_r <= WINDOW_CYC;
			// Watchdog only; the status poll is the real completion signal
			wd_r <= (cmd_op == flash_host_pkg::OP_POLL_ERASE) ? ERASE_TO_CYC : PROG_TO_CYC;
			poll_addr_r <= cmd_addr;
		end else if (cmd_fire && pd_take) begin
			tmr_r <= PD_EXIT_CYC - 32'h0000_0001;
		end else begin
			if (tmr_r != 32'h0000_0000) begin
				tmr_r <= tmr_r - 32'h0000_0001;
			end
			if (wd_r != 32'h0000_0000) begin
				wd_r <= wd_r - 32'h0000_0001;
			end
		end
	end

	// Page spacing is counted from the end of each load cycle
	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			gap_r <= '0;
			page_open_r <= 1'b0;
			page_late_r <= 1'b0;
		end else begin
			page_late_r <= cmd_fire && cmd_op == flash_host_pkg::OP_PAGE &&
				page_open_r && gap_r > LOAD_MAX_CYC;
			if (st_r == flash_host_pkg::ST_CYCLE && cyc_done && page_open_r && gap_r == '0) begin
				gap_r <= '0;
			end else if (cmd_fire && cmd_op == flash_host_pkg::OP_PAGE) begin
				page_open_r <= 1'b1;
				gap_r <= '0;
			end else if (cmd_fire) begin
				page_open_r <= 1'b0;
			end else if (page_open_r && cyc_idle && gap_r <= LOAD_MAX_CYC) begin
				gap_r <= gap_r + 16'h0001;
			end
		end
	end

	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			rsp_valid_r <= 1'b0;
			rsp_timeout_r <= 1'b0;
			rsp_data_r <= '0;
			rd_op_r <= 1'b0;
		end else begin
			// The op port may move once a command is taken, so a read is remembered
			if (cmd_fire) begin
				rd_op_r <= (cmd_op == flash_host_pkg::OP_READ);
			end
			rsp_valid_r <= (st_r == flash_host_pkg::ST_CYCLE && cyc_done &&
				rd_op_r) || (poll_end && (poll_ready || wd_r == 32'h0000_0000));
			if (cyc_done) begin
				rsp_data_r <= cyc_rdata;
				rsp_timeout_r <= poll_end && !poll_ready;
			end
		end
	end

	// Helper for the recovery check below
	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			since_pd_r <= 8'hFF;
		end else if (!pd_n_r) begin
			since_pd_r <= 8'h00;
		end else if (since_pd_r != 8'hFF) begin
			since_pd_r <= since_pd_r + 8'h01;
		end
	end

	property p_write_qualify;
		@(posedge sys_clk) disable iff (!resetn)
		!we_n |-> !chip_select_a_n && !chip_select_b_n && oe_n && deep_powerdown_n;
	endproperty
	a_write_qualify: assert property (p_write_qualify) else $error("write while inhibited");

	property p_width_static;
		@(posedge sys_clk) disable iff (!resetn)
		init_r |=> $stable(width_select);
	endproperty
	a_width_static: assert property (p_width_static) else $error("width select moved");

	property p_page_gap;
		@(posedge sys_clk) disable iff (!resetn)
		cmd_fire && cmd_op == flash_host_pkg::OP_PAGE && page_open_r |-> gap_r >= LOAD_MIN_CYC;
	endproperty
	a_page_gap: assert property (p_page_gap) else $error("page loads too close");

	property p_pd_recovery;
		@(posedge sys_clk) disable iff (!resetn)
		$fell(we_n) |-> since_pd_r >= PD_EXIT_CHK;
	endproperty
	a_pd_recovery: assert property (p_pd_recovery) else $error("strobe too soon after wake");

	property p_poll_done;
		@(posedge sys_clk) disable iff (!resetn)
		poll_end && poll_ready |=> rsp_valid && !rsp_timeout &&
			rsp_data[`FH_READY_BIT] && st_r == flash_host_pkg::ST_IDLE;
	endproperty
	a_poll_done: assert property (p_poll_done) else $error("poll completion lost");

	property p_poll_watchdog;
		@(posedge sys_clk) disable iff (!resetn)
		poll_end && !poll_ready && wd_r == 32'h0000_0000 |=> rsp_valid && rsp_timeout;
	endproperty
	a_poll_watchdog: assert property (p_poll_watchdog) else $error("watchdog not reported");

	c_page_pair: cover property (@(posedge sys_clk) disable iff (!resetn)
		cmd_fire && cmd_op == flash_host_pkg::OP_PAGE && page_open_r);
	c_poll_ok: cover property (@(posedge sys_clk) disable iff (!resetn)
		poll_end && poll_ready);
	c_pd_wake: cover property (@(posedge sys_clk) disable iff (!resetn)
		$rose(deep_powerdown_n));

endmodule

// >>> tb/flash_dev_model.sv
`timescale 1ns/1ps
module flash_dev_model #(
	parameter int AW = 20,
	parameter int DW = 16,
	parameter logic [7:0] UNLOCK_A = 8'hAA,
	parameter logic [7:0] UNLOCK_B = 8'h55,
	parameter logic [7:0] CMD_PROG = 8'h10,
	parameter logic [7:0] CMD_ERASE = 8'h20,
	parameter int PAGE_WIN_NS = 1000,
	parameter int PROG_NS = 2000,
	parameter int ERASE_NS = 8000,
	parameter int PROG_TO_NS = 150000,
	parameter int ERASE_TO_NS = 2000000
) (
	input wire logic chip_select_a_n,
	input wire logic chip_select_b_n,
	input wire logic oe_n,
	input wire logic we_n,
	input wire logic width_select,
	input wire logic deep_powerdown_n,
	input wire logic [AW-1:0] addr_pin,
	input wire logic [DW-1:0] dq_out,
	input wire logic dq_oe,
	output logic [DW-1:0] dq_in,
	output logic ready_busy_out
);
	logic busy = 1'b0;
	logic page_mode = 1'b0;
	logic status_mode = 1'b0;
	logic lockout = 1'b0;
	logic width_latched = 1'b0;
	logic [DW-1:0] last_q = '0;
	int seq = 0;
	int accepted = 0;
	realtime t_fall = 0;
	realtime t_last = 0;
	realtime t_end = 0;
	wire sel = !chip_select_a_n && !chip_select_b_n && deep_powerdown_n;
	wire [DW-1:0] rd_val = status_mode ? {8'h00, !busy, 7'h00} : {addr_pin[7:0], ~addr_pin[7:0]};
	assign ready_busy_out = !busy;
	// Released bus shows the inverse of the last value so stale data cannot pass
	assign dq_in = (sel && !oe_n) ? rd_val : ~last_q;
	always @(posedge oe_n) last_q = rd_val;
	always @(negedge we_n) begin
		t_fall = $realtime;
		if (seq == 2) width_latched = width_select;
	end
	always @(posedge we_n) begin
		if (sel && oe_n && dq_oe && $realtime - t_fall >= 10 && !lockout && !busy) begin
			accepted++;
			if (page_mode) t_last = $realtime;
			else if (seq == 0) seq = (dq_out[7:0] == UNLOCK_A) ? 1 : 0;
			else if (seq == 1) seq = (dq_out[7:0] == UNLOCK_B) ? 2 : 0;
			else begin
				seq = 0;
				status_mode = 1'b1;
				if (dq_out[7:0] == CMD_ERASE) begin
					busy = 1'b1;
					t_end = $realtime + ((ERASE_NS < ERASE_TO_NS) ? ERASE_NS : ERASE_TO_NS);
				end else if (dq_out[7:0] == CMD_PROG) begin
					page_mode = 1'b1;
					t_last = $realtime;
				end
			end
		end
	end
	always #5 begin
		if (!deep_powerdown_n || lockout) begin
			busy = 1'b0;
			page_mode = 1'b0;
			status_mode = 1'b0;
			seq = 0;
		end else if (page_mode && $realtime - t_last >= PAGE_WIN_NS) begin
			page_mode = 1'b0;
			busy = 1'b1;
			t_end = $realtime + ((PROG_NS < PROG_TO_NS) ? PROG_NS : PROG_TO_NS);
		end else if (busy && $realtime >= t_end) busy = 1'b0;
	end
endmodule

// >>> tb/tb_top.sv
`timescale 1ns/1ps
module tb_top;
	logic sys_clk = 1'b0;
	logic resetn = 1'b0;
	logic cmd_valid = 1'b0;
	flash_host_pkg::op_e cmd_op = flash_host_pkg::OP_WRITE;
	logic [19:0] cmd_addr = '0;
	logic [15:0] cmd_data = '0;
	logic word_mode_strap = 1'b1;
	logic cmd_ready, rsp_valid, rsp_timeout, page_late, chip_select_a_n, chip_select_b_n;
	logic oe_n, we_n, width_select, deep_powerdown_n, dq_oe, ready_busy_out;
	logic [15:0] rsp_data, dq_out, dq_in;
	logic [19:0] addr_pin;
	int failures = 0;
	int total_checks = 0;
	int cyc = 0, fall_cyc = 0, prev_fall = 0, pd_rise = 0, bad = 0, low_cnt = 0;
	logic rb_low_seen = 1'b0, late_seen = 1'b0;
	always #5 sys_clk = ~sys_clk;
	always @(posedge sys_clk) begin
		cyc++;
		if (!we_n) begin
			low_cnt++;
			if (chip_select_a_n | chip_select_b_n | !oe_n) bad++;
		end
		if (!ready_busy_out) rb_low_seen = 1'b1;
		if (page_late) late_seen = 1'b1;
	end
	always @(negedge we_n) begin
		prev_fall = fall_cyc;
		fall_cyc = cyc;
	end
	always @(posedge deep_powerdown_n) pd_rise = cyc;
	flash_host_ctrl #(.WINDOW_CYC(150), .ERASE_TO_CYC(400), .PROG_TO_CYC(1000)) flash_host_ctrl_inst (
		.sys_clk(sys_clk), .resetn(resetn), .word_mode_strap(word_mode_strap),
		.cmd_valid(cmd_valid),
		.cmd_ready(cmd_ready), .cmd_op(cmd_op), .cmd_addr(cmd_addr), .cmd_data(cmd_data),
		.rsp_valid(rsp_valid), .rsp_data(rsp_data), .rsp_timeout(rsp_timeout),
		.page_late(page_late), .chip_select_a_n(chip_select_a_n),
		.chip_select_b_n(chip_select_b_n), .oe_n(oe_n), .we_n(we_n),
		.width_select(width_select), .deep_powerdown_n(deep_powerdown_n), .addr_pin(addr_pin),
		.dq_out(dq_out), .dq_oe(dq_oe), .dq_in(dq_in), .ready_busy_out(ready_busy_out));
	flash_dev_model flash_dev_model_inst (
		.chip_select_a_n(chip_select_a_n), .chip_select_b_n(chip_select_b_n), .oe_n(oe_n),
		.we_n(we_n), .width_select(width_select), .deep_powerdown_n(deep_powerdown_n),
		.addr_pin(addr_pin), .dq_out(dq_out), .dq_oe(dq_oe), .dq_in(dq_in),
		.ready_busy_out(ready_busy_out));
	task automatic check(string what, logic [31:0] exp, logic [31:0] got);
		total_checks++;
		if (got !== exp) begin
			$display("[ERR] %s expected %0h seen %0h", what, exp, got);
			failures++;
		end
	endtask
	task automatic tally_and_finish();
		$display("checks %0d mismatches %0d", total_checks, failures);
		if (failures == 0 && total_checks > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask
	task automatic give_up(string what);
		$display("[ERR] %s expected done seen timeout", what);
		failures++;
		tally_and_finish();
	endtask
	task automatic issue(flash_host_pkg::op_e op, logic [19:0] a, logic [15:0] d);
		int n;
		n = 0;
		@(negedge sys_clk);
		cmd_valid = 1'b1;
		cmd_op = op;
		cmd_addr = a;
		cmd_data = d;
		while (cmd_ready !== 1'b1) begin
			@(negedge sys_clk);
			n++;
			if (n > 5000) give_up("cmd_ready");
		end
		@(negedge sys_clk);
		cmd_valid = 1'b0;
	endtask
	task automatic wait_rsp(int lim);
		int n;
		n = 0;
		do begin
			@(posedge sys_clk);
			#1;
			n++;
			if (n > lim) give_up("rsp_valid");
		end while (rsp_valid !== 1'b1);
	endtask
	task automatic do_write(flash_host_pkg::op_e op, logic [19:0] a, logic [15:0] d);
		int acc0;
		acc0 = flash_dev_model_inst.accepted;
		low_cnt = 0;
		bad = 0;
		issue(op, a, d);
		repeat (20) @(posedge sys_clk);
		check("we_n low cycles", 6, low_cnt);
		check("strobe qualifiers", 0, bad);
		check("writes taken", acc0 + 1, flash_dev_model_inst.accepted);
	endtask
	task automatic t_read(logic [19:0] a);
		issue(flash_host_pkg::OP_READ, a, 16'h0000);
		wait_rsp(60);
		check("array read", {a[7:0], ~a[7:0]}, rsp_data);
		$display("read test done");
	endtask
	task automatic t_program();
		do_write(flash_host_pkg::OP_WRITE, 20'h05555, 16'h00AA);
		do_write(flash_host_pkg::OP_WRITE, 20'h02AAA, 16'h0055);
		do_write(flash_host_pkg::OP_WRITE, 20'h05555, 16'h0010);
		check("width latched", 1, flash_dev_model_inst.width_latched);
		do_write(flash_host_pkg::OP_PAGE, 20'h00040, 16'h1234);
		do_write(flash_host_pkg::OP_PAGE, 20'h00041, 16'h5678);
		check("page load gap", 1, (fall_cyc - prev_fall) >= 36);
		check("page_late", 0, late_seen);
		issue(flash_host_pkg::OP_POLL_PROG, 20'h00040, 16'h0000);
		wait_rsp(3000);
		check("busy seen", 1, rb_low_seen);
		check("status ready bit", 1, rsp_data[7]);
		check("poll timeout", 0, rsp_timeout);
		check("pin ready", 1, ready_busy_out);
		$display("program test done");
	endtask
	task automatic t_erase();
		do_write(flash_host_pkg::OP_WRITE, 20'h05555, 16'h00AA);
		do_write(flash_host_pkg::OP_WRITE, 20'h02AAA, 16'h0055);
		do_write(flash_host_pkg::OP_WRITE, 20'h05555, 16'h0020);
		issue(flash_host_pkg::OP_POLL_ERASE, 20'h00000, 16'h0000);
		wait_rsp(3000);
		check("erase watchdog", 1, rsp_timeout);
		check("status busy bit", 0, rsp_data[7]);
		$display("erase test done");
	endtask
	task automatic t_powerdown();
		issue(flash_host_pkg::OP_PD_ENTER, 20'h00000, 16'h0000);
		check("powerdown pin", 0, deep_powerdown_n);
		repeat (3) @(posedge sys_clk);
		check("ready in powerdown", 1, ready_busy_out);
		issue(flash_host_pkg::OP_PD_EXIT, 20'h00000, 16'h0000);
		do_write(flash_host_pkg::OP_WRITE, 20'h00000, 16'h00F0);
		check("exit to strobe", 1, (fall_cyc - pd_rise) >= 100);
		$display("powerdown test done");
	endtask
	task automatic t_page_late();
		do_write(flash_host_pkg::OP_PAGE, 20'h00100, 16'h0000);
		repeat (3100) @(posedge sys_clk);
		late_seen = 1'b0;
		do_write(flash_host_pkg::OP_PAGE, 20'h00101, 16'h0000);
		check("page_late on slow load", 1, late_seen);
		$display("page late test done");
	endtask
	task automatic t_byte_reset();
		@(negedge sys_clk);
		resetn = 1'b0;
		word_mode_strap = 1'b0;
		repeat (3) @(negedge sys_clk);
		check("cs_n in mid reset", 1, chip_select_a_n & chip_select_b_n);
		check("cmd_ready in mid reset", 0, cmd_ready);
		resetn = 1'b1;
		@(posedge sys_clk);
		#1;
		check("width strap byte", 0, width_select);
		do_write(flash_host_pkg::OP_WRITE, 20'h05555, 16'h00AA);
		do_write(flash_host_pkg::OP_WRITE, 20'h02AAA, 16'h0055);
		do_write(flash_host_pkg::OP_WRITE, 20'h05555, 16'h0010);
		check("width latched byte", 0, flash_dev_model_inst.width_latched);
		$display("byte reset test done");
	endtask
	initial begin
		repeat (5) @(posedge sys_clk);
		#1;
		check("cs_n in reset", 1, chip_select_a_n & chip_select_b_n);
		check("strobes in reset", 2'b11, {oe_n, we_n});
		check("dq_oe in reset", 0, dq_oe);
		check("cmd_ready in reset", 0, cmd_ready);
		@(negedge sys_clk);
		resetn = 1'b1;
		repeat (3) @(posedge sys_clk);
		#1;
		check("width strap", 1, width_select);
		$display("reset test done");
		t_read(20'h00123);
		t_program();
		t_erase();
		t_powerdown();
		t_page_late();
		t_read(20'h0007A);
		t_byte_reset();
		tally_and_finish();
	end
endmodule
